/* hw/fpe_guard.sv */
// Flash program and erase sequencer with lock, page and sector guards.
`timescale 1ns/1ps
`default_nettype none
`include "fpe_cfg.svh"

module fpe_guard
    import fpe_pkg::*;
#(
    parameter int unsigned SECT_SHIFT = `FPE_SECT_SHIFT,
    parameter int unsigned PROG_US = `FPE_PROG_TIME_US,
    parameter int unsigned PERASE_US = `FPE_PERASE_TIME_US,
    parameter int unsigned MERASE_US = `FPE_MERASE_TIME_US
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_dbg,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic read_guard_option,
    input wire logic write_guard_option,
    input wire logic prog_req,
    input wire logic prog_dbg,
    input wire logic [15:0] prog_addr,
    input wire logic [7:0] prog_data,
    output logic prog_done,
    output logic prog_refused,
    input wire logic dbg_rd_req,
    input wire logic [15:0] dbg_rd_addr,
    output logic dbg_rd_ok,
    output logic dbg_rd_refused,
    input wire logic [7:0] flash_rdata,
    output logic flash_prog,
    output logic [15:0] flash_addr,
    output logic [7:0] flash_wdata,
    output logic flash_page_erase,
    output logic flash_mass_erase,
    output logic cpu_stall
);

    // ------------------------------------------------------------------
    // State and timer
    // ------------------------------------------------------------------
    fpe_regs_t s_ff;
    fpe_regs_t nxt_s;
    fpe_op_if op ();

    fpe_timer #(
        .PROG_US(PROG_US),
        .PERASE_US(PERASE_US),
        .MERASE_US(MERASE_US)
    ) u_timer (
        .clock(clock),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .op(op)
    );

    assign op.start = s_ff.tmr_start;
    assign op.kind = s_ff.tmr_kind;
    assign op.khz = s_ff.khz;

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    logic ctrl_wr;
    logic page_wr;
    logic [15:0] page_base;
    logic [2:0] page_sect;
    logic [2:0] prog_sect;
    logic page_prot;
    logic prog_prot;
    logic prog_in_page;
    logic prog_in_info;
    logic prog_ok;

    always_comb begin
        ctrl_wr = reg_wr && (reg_addr == `FPE_ADDR_CTRL_STAT);
        page_wr = reg_wr && (reg_addr == `FPE_ADDR_PAGE_SECT);
        page_base = {s_ff.page[`FPE_PAGE_BITS-1:0],
                     {`FPE_PAGE_SHIFT{1'b0}}};
        page_sect = page_base[SECT_SHIFT +: 3];
        prog_sect = prog_addr[SECT_SHIFT +: 3];
        page_prot = s_ff.sect[page_sect];
        prog_prot = s_ff.sect[prog_sect];
        prog_in_page = prog_addr[15:`FPE_PAGE_SHIFT]
            == s_ff.page[`FPE_PAGE_BITS-1:0];
        prog_in_info = prog_addr >= `FPE_INFO_BASE;
        prog_ok = (s_ff.st == FPE_UNLOCKED)
            && !prog_in_info
            && (write_guard_option || prog_dbg)
            && (prog_in_page || s_ff.mass_all || prog_dbg)
            && (!prog_prot || prog_dbg);
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        nxt_s.tmr_start = 1'b0;
        nxt_s.prog_stb = 1'b0;
        nxt_s.perase_stb = 1'b0;
        nxt_s.merase_stb = 1'b0;
        nxt_s.prog_done = 1'b0;
        nxt_s.prog_refused = 1'b0;
        nxt_s.dbg_rd_ok = 1'b0;
        nxt_s.dbg_rd_refused = 1'b0;

        // Debugger reads of user code are refused under the read guard.
        if (dbg_rd_req) begin
            if (read_guard_option && (dbg_rd_addr < `FPE_INFO_BASE)) begin
                nxt_s.dbg_rd_refused = 1'b1;
            end else begin
                nxt_s.dbg_rd_ok = 1'b1;
            end
        end

        // Register reads: status at the shared control address.
        if (reg_rd) begin
            case (reg_addr)
                `FPE_ADDR_CTRL_STAT: begin
                    case (s_ff.st)
                        FPE_UNLK1: nxt_s.rdata = `FPE_STAT_UNLK1;
                        FPE_UNLK2: nxt_s.rdata = `FPE_STAT_UNLK2;
                        FPE_UNLOCKED: nxt_s.rdata = `FPE_STAT_UNLOCKED;
                        FPE_PROG: nxt_s.rdata = `FPE_STAT_PROG;
                        FPE_PERASE: nxt_s.rdata = `FPE_STAT_PERASE;
                        FPE_MERASE: nxt_s.rdata = `FPE_STAT_MERASE;
                        default: nxt_s.rdata = s_ff.sect_sel
                            ? `FPE_STAT_SECT_SEL : `FPE_STAT_LOCKED;
                    endcase
                end
                `FPE_ADDR_PAGE_SECT: nxt_s.rdata = s_ff.sect_sel
                    ? s_ff.sect : s_ff.page;
                `FPE_ADDR_KHZ_HIGH: nxt_s.rdata = s_ff.khz[15:8];
                `FPE_ADDR_KHZ_LOW: nxt_s.rdata = s_ff.khz[7:0];
                default: nxt_s.rdata = 8'h00;
            endcase
        end

        // Frequency setting, high and low halves.
        if (reg_wr && (reg_addr == `FPE_ADDR_KHZ_HIGH)) begin
            nxt_s.khz[15:8] = reg_wdata;
        end
        if (reg_wr && (reg_addr == `FPE_ADDR_KHZ_LOW)) begin
            nxt_s.khz[7:0] = reg_wdata;
        end

        // Any control write other than 5EH deselects sector protection.
        if (ctrl_wr) begin
            nxt_s.sect_sel = (reg_wdata == `FPE_CMD_SECT_SEL);
        end

        // Writes at the shared page and sector address.
        if (page_wr && s_ff.sect_sel) begin
            if (reg_dbg) begin
                nxt_s.sect = reg_wdata;
            end else begin
                nxt_s.sect = s_ff.sect | reg_wdata;
            end
        end

        case (s_ff.st)
            FPE_LOCKED: begin
                nxt_s.mass_all = 1'b0;
                if (page_wr && !s_ff.sect_sel) begin
                    nxt_s.page = reg_wdata;
                end
                if (ctrl_wr && (reg_wdata == `FPE_CMD_UNLOCK1)) begin
                    nxt_s.st = FPE_UNLK1;
                end
            end
            FPE_UNLK1: begin
                if (ctrl_wr) begin
                    if (reg_wdata == `FPE_CMD_UNLOCK2) begin
                        // The debugger needs no second page write.
                        nxt_s.st = reg_dbg ? FPE_UNLOCKED : FPE_UNLK2;
                    end else begin
                        nxt_s.st = FPE_LOCKED;
                    end
                end else if (page_wr) begin
                    nxt_s.st = FPE_LOCKED;
                end
            end
            FPE_UNLK2: begin
                if (ctrl_wr) begin
                    nxt_s.st = FPE_LOCKED;
                end else if (page_wr) begin
                    if (reg_wdata == s_ff.page) begin
                        nxt_s.st = FPE_UNLOCKED;
                    end else begin
                        nxt_s.st = FPE_LOCKED;
                    end
                end
            end
            FPE_UNLOCKED: begin
                if (page_wr && reg_dbg && !s_ff.sect_sel) begin
                    nxt_s.page = reg_wdata;
                end
                if (ctrl_wr) begin
                    nxt_s.st = FPE_LOCKED;
                    if (reg_wdata == `FPE_CMD_PAGE_ERASE
                        && (write_guard_option || reg_dbg)
                        && (!page_prot || reg_dbg)) begin
                        nxt_s.st = FPE_PERASE;
                        nxt_s.perase_stb = 1'b1;
                        nxt_s.f_addr = page_base;
                        nxt_s.tmr_start = 1'b1;
                        nxt_s.tmr_kind = FPE_OP_PERASE;
                        nxt_s.stall = !reg_dbg;
                    end else if (reg_wdata == `FPE_CMD_MASS_ERASE
                        && reg_dbg) begin
                        nxt_s.st = FPE_MERASE;
                        nxt_s.merase_stb = 1'b1;
                        nxt_s.f_addr = 16'h0000;
                        nxt_s.tmr_start = 1'b1;
                        nxt_s.tmr_kind = FPE_OP_MERASE;
                    end
                end else if (prog_req) begin
                    if (prog_ok) begin
                        nxt_s.st = FPE_PROG;
                        nxt_s.prog_stb = 1'b1;
                        nxt_s.f_addr = prog_addr;
                        nxt_s.f_wdata = prog_data & flash_rdata;
                        nxt_s.tmr_start = 1'b1;
                        nxt_s.tmr_kind = FPE_OP_PROG;
                        nxt_s.stall = !prog_dbg;
                    end else begin
                        nxt_s.prog_refused = 1'b1;
                    end
                end
            end
            FPE_PROG: begin
                if (op.done) begin
                    nxt_s.st = FPE_UNLOCKED;
                    nxt_s.stall = 1'b0;
                    nxt_s.prog_done = 1'b1;
                end
            end
            FPE_PERASE: begin
                if (op.done) begin
                    nxt_s.st = FPE_LOCKED;
                    nxt_s.stall = 1'b0;
                end
            end
            FPE_MERASE: begin
                if (op.done) begin
                    // Every page below the information area stays open for programming after this, unless its sector is protected.
                    nxt_s.st = FPE_UNLOCKED;
                    nxt_s.mass_all = 1'b1;
                end
            end
            default: nxt_s.st = FPE_LOCKED;
        endcase

        // Program requests outside the open state are answered with prog_refused.
        if (prog_req && (s_ff.st != FPE_UNLOCKED)) begin
            nxt_s.prog_refused = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s_ff <= '0;
            s_ff.st <= FPE_LOCKED;
            s_ff.page <= `FPE_RST_PAGE;
            s_ff.sect <= `FPE_RST_SECT;
            s_ff.khz <= `FPE_RST_KHZ;
        end else if (clk_en) begin
            s_ff <= nxt_s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata = s_ff.rdata;
    assign prog_done = s_ff.prog_done;
    assign prog_refused = s_ff.prog_refused;
    assign dbg_rd_ok = s_ff.dbg_rd_ok;
    assign dbg_rd_refused = s_ff.dbg_rd_refused;
    assign flash_prog = s_ff.prog_stb;
    assign flash_addr = s_ff.f_addr;
    assign flash_wdata = s_ff.f_wdata;
    assign flash_page_erase = s_ff.perase_stb;
    assign flash_mass_erase = s_ff.merase_stb;
    assign cpu_stall = s_ff.stall;

endmodule : fpe_guard
`default_nettype wire

/* hw/fpe_cfg.svh */
// Constants of the flash program and erase guard: offsets, codes, timing.
`ifndef FPE_CFG_SVH
`define FPE_CFG_SVH

// ----------------------------------------------------------------------
// Register file addresses
// ----------------------------------------------------------------------
`define FPE_ADDR_CTRL_STAT 12'hFF8
`define FPE_ADDR_PAGE_SECT 12'hFF9
`define FPE_ADDR_KHZ_HIGH 12'hFFA
`define FPE_ADDR_KHZ_LOW 12'hFFB

// ----------------------------------------------------------------------
// Control commands
// ----------------------------------------------------------------------
`define FPE_CMD_RESET 8'h00
`define FPE_CMD_UNLOCK1 8'h73
`define FPE_CMD_UNLOCK2 8'h8C
`define FPE_CMD_PAGE_ERASE 8'h95
`define FPE_CMD_MASS_ERASE 8'h63
`define FPE_CMD_SECT_SEL 8'h5E

// ----------------------------------------------------------------------
// Status codes
// ----------------------------------------------------------------------
`define FPE_STAT_LOCKED 8'h00
`define FPE_STAT_UNLK1 8'h01
`define FPE_STAT_UNLK2 8'h02
`define FPE_STAT_UNLOCKED 8'h03
`define FPE_STAT_SECT_SEL 8'h04
`define FPE_STAT_PROG 8'h08
`define FPE_STAT_PERASE 8'h10
`define FPE_STAT_MERASE 8'h20

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define FPE_PAGE_SHIFT 9
`define FPE_PAGE_BITS 7
`define FPE_SECT_SHIFT 10
`define FPE_INFO_BASE 16'hFE00
`define FPE_RST_PAGE 8'h00
`define FPE_RST_SECT 8'h00
`define FPE_RST_KHZ 16'h0000

// ----------------------------------------------------------------------
// Operation times in microseconds, and the kHz-to-cycle divisor
// ----------------------------------------------------------------------
`define FPE_PROG_TIME_US 40
`define FPE_PERASE_TIME_US 10000
`define FPE_MERASE_TIME_US 200000
`define FPE_KHZ_PER_MHZ 1000

`endif

/* hw/fpe_pkg.sv */
// Types of the flash program and erase guard.
package fpe_pkg;

    typedef enum logic [2:0] {
        FPE_LOCKED,
        FPE_UNLK1,
        FPE_UNLK2,
        FPE_UNLOCKED,
        FPE_PROG,
        FPE_PERASE,
        FPE_MERASE
    } fpe_state_t;

    typedef enum logic [1:0] {
        FPE_OP_PROG,
        FPE_OP_PERASE,
        FPE_OP_MERASE
    } fpe_op_t;

    typedef struct packed {
        fpe_state_t st;
        logic sect_sel;
        logic mass_all;
        logic [7:0] page;
        logic [7:0] sect;
        logic [15:0] khz;
        logic [7:0] rdata;
        logic tmr_start;
        fpe_op_t tmr_kind;
        logic prog_stb;
        logic [15:0] f_addr;
        logic [7:0] f_wdata;
        logic perase_stb;
        logic merase_stb;
        logic stall;
        logic prog_done;
        logic prog_refused;
        logic dbg_rd_ok;
        logic dbg_rd_refused;
    } fpe_regs_t;

    typedef struct packed {
        logic run;
        logic done;
        logic [31:0] cnt;
    } fpe_tmr_t;

endpackage : fpe_pkg

/* hw/fpe_op_if.sv */
// Handshake between the guard sequencer and its operation timer.
`timescale 1ns/1ps
`default_nettype none
interface fpe_op_if;
    import fpe_pkg::*;
    logic start;
    fpe_op_t kind;
    logic [15:0] khz;
    logic done;
    modport ctl (output start, output kind, output khz, input done);
    modport tmr (input start, input kind, input khz, output done);
endinterface : fpe_op_if
`default_nettype wire

/* hw/fpe_timer.sv */
// Operation timer scaled by the clock frequency setting in kHz.
`timescale 1ns/1ps
`default_nettype none
`include "fpe_cfg.svh"
module fpe_timer
    import fpe_pkg::*;
#(
    parameter int unsigned PROG_US = `FPE_PROG_TIME_US,
    parameter int unsigned PERASE_US = `FPE_PERASE_TIME_US,
    parameter int unsigned MERASE_US = `FPE_MERASE_TIME_US
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    fpe_op_if.tmr op
);

    fpe_tmr_t t_ff;
    fpe_tmr_t nxt_t;
    logic [39:0] dur_us;
    logic [39:0] cycles;

    // Duration in cycles is kHz times microseconds over one thousand.
    always_comb begin
        case (op.kind)
            FPE_OP_PERASE: dur_us = 40'(PERASE_US);
            FPE_OP_MERASE: dur_us = 40'(MERASE_US);
            default: dur_us = 40'(PROG_US);
        endcase
        cycles = ({24'h0, op.khz} * dur_us) / 40'(`FPE_KHZ_PER_MHZ);
        if (cycles == 40'h0) begin
            cycles = 40'h1;
        end
    end

    always_comb begin
        nxt_t = t_ff;
        nxt_t.done = 1'b0;
        if (op.start) begin
            nxt_t.run = 1'b1;
            nxt_t.cnt = cycles[31:0];
        end else if (t_ff.run) begin
            if (t_ff.cnt <= 32'h1) begin
                nxt_t.run = 1'b0;
                nxt_t.done = 1'b1;
                nxt_t.cnt = 32'h0;
            end else begin
                nxt_t.cnt = t_ff.cnt - 32'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            t_ff <= '0;
        end else if (clk_en) begin
            t_ff <= nxt_t;
        end
    end

    assign op.done = t_ff.done;

endmodule : fpe_timer
`default_nettype wire

/* tb/fpe_guard_assertions.sv */
// Port-level checks of the flash program and erase guard.
`timescale 1ns/1ps
`default_nettype none
`include "fpe_cfg.svh"
module fpe_guard_assertions (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic reg_dbg,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic read_guard_option,
    input wire logic write_guard_option,
    input wire logic prog_req,
    input wire logic prog_dbg,
    input wire logic [15:0] prog_addr,
    input wire logic [7:0] prog_data,
    input wire logic prog_done,
    input wire logic prog_refused,
    input wire logic dbg_rd_req,
    input wire logic [15:0] dbg_rd_addr,
    input wire logic dbg_rd_refused,
    input wire logic [7:0] flash_rdata,
    input wire logic flash_prog,
    input wire logic [15:0] flash_addr,
    input wire logic [7:0] flash_wdata,
    input wire logic flash_page_erase,
    input wire logic flash_mass_erase,
    input wire logic cpu_stall
);
    // ------------
    // Checks
    // ------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    a_reset_quiet: assert property ($fell(sys_rst) |->
        !(flash_prog || flash_page_erase || flash_mass_erase || cpu_stall ||
        prog_done))
        else $error("flash activity right after reset");
    a_prog_answer: assert property (prog_req |=>
        flash_prog != prog_refused)
        else $error("program request not answered once");
    a_user_stall: assert property (prog_req && !prog_dbg ##1
        flash_prog |-> cpu_stall)
        else $error("core not stalled while programming");
    a_done_drop: assert property (prog_done |-> !cpu_stall)
        else $error("stall held past completion");
    a_wdata_and: assert property (flash_prog |->
        flash_wdata == $past(prog_data & flash_rdata))
        else $error("programmed byte sets bits");
    a_prog_addr: assert property (flash_prog |->
        flash_addr == $past(prog_addr))
        else $error("byte programmed at wrong address");
    a_info_refuse: assert property (prog_req &&
        prog_addr >= `FPE_INFO_BASE |=> prog_refused)
        else $error("information area programmed");
    a_guard_refuse: assert property (prog_req && !prog_dbg &&
        !write_guard_option |=> prog_refused)
        else $error("user program with write guard low");
    a_mass_dbg: assert property (flash_mass_erase |->
        $past(reg_wr && reg_dbg && reg_addr == `FPE_ADDR_CTRL_STAT
        && reg_wdata == `FPE_CMD_MASS_ERASE))
        else $error("mass erase without debugger command");
    a_perase_cmd: assert property (flash_page_erase |->
        flash_addr[8:0] == 9'h000 && $past(reg_wr
        && reg_addr == `FPE_ADDR_CTRL_STAT
        && reg_wdata == `FPE_CMD_PAGE_ERASE))
        else $error("page erase without its command");
    a_rd_guard: assert property (dbg_rd_req && read_guard_option &&
        dbg_rd_addr < `FPE_INFO_BASE |=> dbg_rd_refused)
        else $error("guarded debugger read allowed");
endmodule : fpe_guard_assertions
bind fpe_guard fpe_guard_assertions u_fpe_guard_assertions (
    .clock(clock), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_dbg(reg_dbg),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .prog_req(prog_req),
    .read_guard_option(read_guard_option), .prog_dbg(prog_dbg),
    .write_guard_option(write_guard_option), .prog_addr(prog_addr),
    .prog_data(prog_data), .prog_done(prog_done), .cpu_stall(cpu_stall),
    .prog_refused(prog_refused), .dbg_rd_req(dbg_rd_req),
    .dbg_rd_addr(dbg_rd_addr), .dbg_rd_refused(dbg_rd_refused),
    .flash_rdata(flash_rdata), .flash_prog(flash_prog),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_page_erase(flash_page_erase), .flash_mass_erase(flash_mass_erase)
);
`default_nettype wire

/* tb/fpe_flash_model.sv */
// Behavioural flash array behind the guard's array port.
`timescale 1ns/1ps
`default_nettype none
module fpe_flash_model (
    input wire logic clock,
    input wire logic [15:0] rd_addr,
    input wire logic prog,
    input wire logic page_erase,
    input wire logic mass_erase,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    // ------------
    // Array
    // ------------
    logic [7:0] mem [0:65535];
    assign rdata = mem[rd_addr];
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'hFF;
        end
    end
    // Programming can only clear bits; erases restore all ones.
    always @(posedge clock) begin
        if (prog) begin
            mem[addr] <= mem[addr] & wdata;
        end
        if (page_erase) begin
            for (int i = 0; i < 512; i++) begin
                mem[{addr[15:9], 9'h000} + 16'(i)] <= 8'hFF;
            end
        end
        if (mass_erase) begin
            for (int i = 0; i < 65536; i++) begin
                mem[i] <= 8'hFF;
            end
        end
    end
endmodule : fpe_flash_model
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench of the flash program and erase guard.
`timescale 1ns/1ps
`default_nettype none
`include "fpe_cfg.svh"
`define CHK(g, e) begin if ((g) !== (e)) begin \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); \
    num_errors++; end n_compared++; end
module tb_top;
    // ------------
    // Signals
    // ------------
    localparam logic [11:0] CS = `FPE_ADDR_CTRL_STAT;
    localparam logic [11:0] PS = `FPE_ADDR_PAGE_SECT;
    logic clock = 1'h0, sys_rst = 1'h1, clk_en = 1'h1, rd_q = 1'h0;
    logic reg_wr = 1'h0, reg_rd = 1'h0, reg_dbg = 1'h0, prog_req = 1'h0;
    logic prog_dbg = 1'h0, dbg_rd_req = 1'h0, read_guard_option = 1'h0;
    logic write_guard_option = 1'h1;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00, prog_data = 8'h00;
    logic [15:0] prog_addr = 16'h0000, dbg_rd_addr = 16'h0000, a;
    logic [7:0] reg_rdata, flash_rdata, flash_wdata;
    logic [15:0] flash_addr;
    logic prog_done, prog_refused, dbg_rd_ok, dbg_rd_refused, flash_prog;
    logic flash_page_erase, flash_mass_erase, cpu_stall;
    logic [9:0] exp_q [$];
    int num_errors = 0;
    int n_compared = 0;
    fpe_guard #(.PROG_US(2), .PERASE_US(5), .MERASE_US(10)) u_fpe_guard (
        .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_dbg(reg_dbg), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .prog_req(prog_req),
        .read_guard_option(read_guard_option), .prog_dbg(prog_dbg),
        .write_guard_option(write_guard_option), .prog_addr(prog_addr),
        .prog_data(prog_data), .prog_done(prog_done), .cpu_stall(cpu_stall),
        .prog_refused(prog_refused), .dbg_rd_req(dbg_rd_req),
        .dbg_rd_addr(dbg_rd_addr), .dbg_rd_ok(dbg_rd_ok),
        .dbg_rd_refused(dbg_rd_refused), .flash_rdata(flash_rdata),
        .flash_prog(flash_prog), .flash_addr(flash_addr),
        .flash_wdata(flash_wdata), .flash_page_erase(flash_page_erase),
        .flash_mass_erase(flash_mass_erase));
    fpe_flash_model u_fpe_flash_model (.clock(clock), .rd_addr(prog_addr),
        .prog(flash_prog), .page_erase(flash_page_erase),
        .mass_erase(flash_mass_erase), .addr(flash_addr),
        .wdata(flash_wdata), .rdata(flash_rdata));
    initial begin
        forever #10 clock = ~clock;
    end
    // ------------
    // Tasks
    // ------------
    task automatic rs();
        sys_rst <= 1'h1;
        repeat (12) @(posedge clock);
        sys_rst <= 1'h0;
    endtask : rs
    task automatic wr(input logic [11:0] ad, input logic [7:0] d,
                      input logic g = 1'h0);
        @(posedge clock);
        reg_wr <= 1'h1;
        reg_dbg <= g;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'h0;
        reg_dbg <= 1'h0;
    endtask : wr
    task automatic rd(input logic [11:0] ad, input logic [7:0] e);
        exp_q.push_back({2'h0, e});
        @(posedge clock);
        reg_rd <= 1'h1;
        reg_addr <= ad;
        @(posedge clock);
        reg_rd <= 1'h0;
    endtask : rd
    task automatic un(input logic [7:0] p, input logic g);
        wr(PS, p, g);
        wr(CS, 8'h73, g);
        rd(CS, 8'h01);
        wr(CS, 8'h8C, g);
        if (!g) begin
            rd(CS, 8'h02);
            wr(PS, p);
        end
        rd(CS, 8'h03);
    endtask : un
    task automatic pg(input logic [15:0] ad, input logic g, input logic ok);
        logic [7:0] d;
        d = 8'($urandom);
        if (ok) begin
            exp_q.push_back({2'h2, d & u_fpe_flash_model.mem[ad]});
        end
        exp_q.push_back({2'h1, 7'h00, ok});
        @(posedge clock);
        prog_req <= 1'h1;
        prog_dbg <= g;
        prog_addr <= ad;
        prog_data <= d;
        @(posedge clock);
        prog_req <= 1'h0;
        for (int n = 0; n < 60; n++) begin
            @(negedge clock);
            if (prog_done === 1'h1 || prog_refused === 1'h1) break;
        end
    endtask : pg
    task automatic dr(input logic [15:0] ad, input logic ok);
        exp_q.push_back({2'h1, 7'h00, ok});
        @(posedge clock);
        dbg_rd_req <= 1'h1;
        dbg_rd_addr <= ad;
        @(posedge clock);
        dbg_rd_req <= 1'h0;
        @(posedge clock);
    endtask : dr
    task automatic take(input logic [9:0] g);
        logic [9:0] e;
        e = (exp_q.size() > 0) ? exp_q.pop_front() : 10'h3FF;
        `CHK(g, e)
    endtask : take
    task automatic summarize();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    // Results are matched in order against the noted expectations.
    always @(posedge clock) begin
        rd_q <= reg_rd & clk_en;
    end
    always @(negedge clock) begin
        if (flash_prog) take({2'h2, flash_wdata});
        if (flash_page_erase) take({2'h3, 1'h0, flash_addr[15:9]});
        if (flash_mass_erase) take(10'h380);
        if (prog_done || dbg_rd_ok) take(10'h101);
        if (prog_refused || dbg_rd_refused) take(10'h100);
        if (rd_q) take({2'h0, reg_rdata});
    end
    initial begin
        #400000;
        num_errors++;
        summarize();
    end
    // ------------
    // Scenarios
    // ------------
    initial begin
        void'($urandom(25260));
        a = 16'h0200 + 16'($urandom_range(511));
        rs();
        rd(CS, 8'h00);
        rd(PS, 8'h00);
        rd(12'hF00, 8'h00);
        wr(12'hFFA, 8'h03);
        wr(12'hFFB, 8'hE8);
        pg(a, 1'h0, 1'h0);
        un(8'h01, 1'h0);
        pg(a, 1'h0, 1'h1);
        pg(a, 1'h0, 1'h1);
        pg(16'h0000, 1'h0, 1'h0);
        pg(16'hFE10, 1'h0, 1'h0);
        wr(CS, 8'h00);
        rd(CS, 8'h00);
        pg(a, 1'h0, 1'h0);
        wr(PS, 8'h02);
        wr(CS, 8'h73);
        wr(CS, 8'h8C);
        wr(PS, 8'h03);
        rd(CS, 8'h00);
        wr(CS, 8'h8C);
        rd(CS, 8'h00);
        write_guard_option <= 1'h0;
        un(8'h01, 1'h0);
        pg(a, 1'h0, 1'h0);
        wr(CS, 8'h00);
        write_guard_option <= 1'h1;
        un(8'h01, 1'h0);
        exp_q.push_back(10'h301);
        wr(CS, 8'h95);
        rd(CS, 8'h10);
        for (int n = 0; n < 100 && cpu_stall !== 1'h0; n++) @(posedge clock);
        rd(CS, 8'h00);
        un(8'h01, 1'h0);
        wr(CS, 8'h63);
        rd(CS, 8'h00);
        un(8'h01, 1'h1);
        exp_q.push_back(10'h380);
        wr(CS, 8'h63, 1'h1);
        rd(CS, 8'h20);
        clk_en <= 1'h0;
        repeat (40) @(posedge clock);
        clk_en <= 1'h1;
        rd(CS, 8'h20);
        repeat (30) @(posedge clock);
        rd(CS, 8'h03);
        pg(16'h1000 + 16'($urandom_range(255)), 1'h0, 1'h1);
        wr(CS, 8'h00);
        wr(CS, 8'h5E);
        rd(CS, 8'h04);
        wr(PS, 8'h02);
        wr(PS, 8'h01);
        rd(PS, 8'h03);
        wr(CS, 8'h00);
        un(8'h02, 1'h0);
        pg(16'h0410, 1'h0, 1'h0);
        wr(CS, 8'h00);
        un(8'h02, 1'h1);
        pg(16'h0410, 1'h1, 1'h1);
        wr(CS, 8'h00, 1'h1);
        read_guard_option <= 1'h1;
        dr(16'h0100, 1'h0);
        read_guard_option <= 1'h0;
        dr(16'h0100, 1'h1);
        rs();
        rd(CS, 8'h00);
        un(8'h02, 1'h0);
        pg(16'h0420, 1'h0, 1'h1);
        wr(CS, 8'h00);
        repeat (4) @(posedge clock);
        `CHK(exp_q.size(), 0)
        summarize();
    end
endmodule : tb_top
`default_nettype wire
